// ==== logic/scpd_decoder.v ====
// Overview of operation
// R1: the control byte holds block select in bits 7..3, direction in bit 2, length mode in 1..0.
// R2: block select 00000 is the common block and codes 4n (n>0) are reserved, selecting nothing.
// R3: block select 4n+1 selects the register block of socket n.
// R4: block select 4n+2 selects the transmit buffer of socket n.
// R5: block select 4n+3 selects the receive buffer of socket n.
// R6: block select 11111 selects the receive buffer of socket seven.
// R7: length mode 00 is variable length ended by frame release, 01/10/11 fix 1, 2 and 4 bytes.
// R8: the 16-bit offset is shifted in before the control byte, most significant bit first.
// R9: every data byte is shifted most significant bit first in both directions.
// R10: a reserved block select flags an invalid block and blocks writes and reads for the frame.
`timescale 1ns/100ps
`default_nettype none
`include "scpd_regs.vh"
module scpd_decoder (
  input wire clk,
  input wire nrst,
  input wire sclk,
  input wire frame_select_n,
  input wire mosi,
  output reg miso,
  output reg miso_oe,
  output reg [15:0] offset_r,
  output reg hdr_valid_r,
  output reg [2:0] block_class_r,
  output reg [2:0] socket_r,
  output reg access_direction_r,
  output reg [1:0] length_mode_r,
  output reg [2:0] fixed_len_r,
  output reg invalid_block_r,
  output reg [7:0] wr_data_r,
  output reg wr_stb_r,
  output reg rd_stb_r,
  output reg frame_end_r,
  input wire [7:0] rd_data
);
  localparam ST_IDLE = 2'h0;
  localparam ST_HDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_DONE = 2'h3;

  // map block select to class
  function [2:0] bs_class;
    input [4:0] bs;
    begin
      if (bs == `SCPD_BS_COMMON)
        bs_class = `SCPD_CLS_COMMON; // R2
      else
        case (bs[1:0])
          `SCPD_KIND_REG: bs_class = `SCPD_CLS_SOCK_REG; // R3
          `SCPD_KIND_TX: bs_class = `SCPD_CLS_SOCK_TX; // R4
          `SCPD_KIND_RX: bs_class = `SCPD_CLS_SOCK_RX; // R5 R6
          default: bs_class = `SCPD_CLS_INVALID; // R2
        endcase
    end
  endfunction

  function [2:0] lm_bytes;
    input [1:0] lm;
    begin
      case (lm)
        `SCPD_LM_FIX1: lm_bytes = 3'h1;
        `SCPD_LM_FIX2: lm_bytes = 3'h2;
        `SCPD_LM_FIX4: lm_bytes = 3'h4;
        default: lm_bytes = 3'h0;
      endcase
    end
  endfunction

  wire [2:0] sync_q;
  // select is synced inverted so the flops' reset value reads as released
  scpd_sync #(.W(3)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({sclk, ~frame_select_n, mosi}),
    .q(sync_q)
  );
  wire sclk_s = sync_q[2];
  wire sel_n_s = ~sync_q[1];
  wire mosi_s = sync_q[0];

  reg sclk_d_r;
  reg [1:0] st_r;
  reg [4:0] bitcnt_r;
  reg [23:0] hdr_r;
  reg [2:0] dbit_r;
  reg [7:0] rx_r;
  reg [7:0] tx_r;
  reg [2:0] bytes_r;
  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;
  wire [23:0] hdr_nxt = {hdr_r[22:0], mosi_s};
  wire [4:0] ctrl_bs = hdr_nxt[`SCPD_BS_MSB:`SCPD_BS_LSB]; // R1
  wire [2:0] ctrl_cls = bs_class(ctrl_bs);
  wire ok = ~invalid_block_r; // R10

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_d_r <= 1'b0;
      st_r <= ST_IDLE;
      bitcnt_r <= 5'h00;
      hdr_r <= 24'h000000;
      dbit_r <= 3'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      bytes_r <= 3'h0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      offset_r <= 16'h0000;
      hdr_valid_r <= 1'b0;
      block_class_r <= `SCPD_CLS_NONE;
      socket_r <= 3'h0;
      access_direction_r <= 1'b0;
      length_mode_r <= 2'h0;
      fixed_len_r <= 3'h0;
      invalid_block_r <= 1'b0;
      wr_data_r <= 8'h00;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      frame_end_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      frame_end_r <= 1'b0;
      if (sel_n_s)
      begin
        // release ends the frame in any state
        if (st_r != ST_IDLE)
          frame_end_r <= 1'b1; // R7
        st_r <= ST_IDLE;
        bitcnt_r <= 5'h00;
        dbit_r <= 3'h0;
        miso_oe <= 1'b0;
        miso <= 1'b0;
        hdr_valid_r <= 1'b0;
        invalid_block_r <= 1'b0;
        block_class_r <= `SCPD_CLS_NONE;
        offset_r <= 16'h0000;
        socket_r <= 3'h0;
        access_direction_r <= 1'b0;
        length_mode_r <= 2'h0;
        fixed_len_r <= 3'h0;
      end
      else
        case (st_r)
          ST_IDLE:
          begin
            st_r <= ST_HDR;
            bitcnt_r <= 5'h00;
            miso_oe <= 1'b1;
          end
          ST_HDR:
          begin
            if (rise)
            begin
              hdr_r <= hdr_nxt; // R8
              bitcnt_r <= bitcnt_r + 5'h01;
              if (bitcnt_r == 5'd23)
              begin
                offset_r <= hdr_nxt[23:8]; // R8
                block_class_r <= ctrl_cls;
                socket_r <= ctrl_bs[4:2];
                access_direction_r <= hdr_nxt[`SCPD_DIR_BIT]; // R1
                length_mode_r <= hdr_nxt[`SCPD_LM_MSB:`SCPD_LM_LSB]; // R1
                fixed_len_r <= lm_bytes(hdr_nxt[`SCPD_LM_MSB:`SCPD_LM_LSB]); // R7
                bytes_r <= 3'h0;
                invalid_block_r <= (ctrl_cls == `SCPD_CLS_INVALID); // R10
                hdr_valid_r <= 1'b1;
                dbit_r <= 3'h0;
                st_r <= ST_DATA;
                if (!hdr_nxt[`SCPD_DIR_BIT] && ctrl_cls != `SCPD_CLS_INVALID)
                  rd_stb_r <= 1'b1;
              end
            end
          end
          ST_DATA:
          begin
            if (rd_stb_r)
              tx_r <= rd_data;
            if (fall)
            begin
              miso <= (ok && !access_direction_r) ? tx_r[3'h7 - dbit_r] : 1'b0; // R9 R10
            end
            if (rise)
            begin
              rx_r <= {rx_r[6:0], mosi_s}; // R9
              dbit_r <= dbit_r + 3'h1;
              if (dbit_r == 3'h7)
              begin
                bytes_r <= bytes_r + 3'h1;
                if (access_direction_r && ok)
                begin
                  wr_data_r <= {rx_r[6:0], mosi_s};
                  wr_stb_r <= 1'b1;
                end
                if (!access_direction_r && ok)
                  rd_stb_r <= 1'b1;
                if (fixed_len_r != 3'h0 && bytes_r + 3'h1 == fixed_len_r)
                begin
                  st_r <= ST_DONE; // R7
                  frame_end_r <= 1'b1;
                end
              end
            end
          end
          ST_DONE:
          begin
            // fixed length reached; ignore clocks until release
            miso <= 1'b0;
          end
          default: st_r <= ST_IDLE;
        endcase
    end
  end
endmodule // scpd_decoder
`default_nettype wire

// ==== logic/scpd_regs.vh ====
`ifndef SCPD_REGS_VH
`define SCPD_REGS_VH
// control byte fields
`define SCPD_BS_MSB 7
`define SCPD_BS_LSB 3
`define SCPD_DIR_BIT 2
`define SCPD_LM_MSB 1
`define SCPD_LM_LSB 0
// block select encoding
`define SCPD_BS_COMMON 5'h00
`define SCPD_KIND_RSVD 2'h0
`define SCPD_KIND_REG 2'h1
`define SCPD_KIND_TX 2'h2
`define SCPD_KIND_RX 2'h3
// length modes
`define SCPD_LM_VAR 2'h0
`define SCPD_LM_FIX1 2'h1
`define SCPD_LM_FIX2 2'h2
`define SCPD_LM_FIX4 2'h3
// block class outputs
`define SCPD_CLS_NONE 3'h0
`define SCPD_CLS_COMMON 3'h1
`define SCPD_CLS_SOCK_REG 3'h2
`define SCPD_CLS_SOCK_TX 3'h3
`define SCPD_CLS_SOCK_RX 3'h4
`define SCPD_CLS_INVALID 3'h5
// frame bit counts
`define SCPD_ADDR_BITS 16
`define SCPD_CTRL_BITS 8
`endif

// ==== logic/scpd_sync.v ====
`timescale 1ns/100ps
`default_nettype none
module scpd_sync #(
  parameter W = 3
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // scpd_sync
`default_nettype wire

// ==== sim/scpd_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module scpd_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic frame_select_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic hdr_valid_r,
  input wire logic [2:0] block_class_r,
  input wire logic [2:0] socket_r,
  input wire logic access_direction_r,
  input wire logic [1:0] length_mode_r,
  input wire logic [2:0] fixed_len_r,
  input wire logic invalid_block_r,
  input wire logic wr_stb_r,
  input wire logic rd_stb_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_idle;
    frame_select_n [*6];
  endsequence
  sequence s_hdr;
    hdr_valid_r && $past(hdr_valid_r);
  endsequence
  chk_invalid_class: assert property (hdr_valid_r |-> invalid_block_r == (block_class_r == 3'h5))
    else $error("invalid flag and class disagree");
  chk_fixed_len: assert property (hdr_valid_r |->
    fixed_len_r == ((length_mode_r == 2'h3) ? 3'h4 : {1'b0, length_mode_r}))
    else $error("fixed length wrong");
  chk_no_strobe: assert property (invalid_block_r |-> !wr_stb_r && !rd_stb_r)
    else $error("strobe on invalid block");
  chk_miso_quiet: assert property (invalid_block_r && $past(invalid_block_r, 20) |-> !miso)
    else $error("miso driven on invalid block");
  chk_write_dir: assert property (wr_stb_r |-> access_direction_r && hdr_valid_r)
    else $error("write strobe without write header");
  chk_idle_quiet: assert property (s_idle |-> !miso_oe && !hdr_valid_r)
    else $error("frame state after release");
  chk_common_sock: assert property (hdr_valid_r && block_class_r == 3'h1 |-> socket_r == 3'h0)
    else $error("common block with socket");
  chk_class_hold: assert property (s_hdr |-> $stable(block_class_r) && $stable(socket_r))
    else $error("class changed mid frame");
  chk_class_set: assert property (hdr_valid_r |-> block_class_r != 3'h0)
    else $error("header without class");
endmodule // scpd_asserts
bind scpd_decoder scpd_asserts u_chk (.*);
`default_nettype wire

// ==== sim/scpd_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module scpd_host (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic frame_select_n,
  output logic mosi
);
  initial
  begin
    sclk = 1'b0;
    frame_select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic sel;
    @(posedge clk) frame_select_n <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic bits(input logic [31:0] v, input int n, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi <= v[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      r = {r[30:0], miso};
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
  // released data line shows the inverse of its last bit
  task automatic rel;
    repeat (8) @(posedge clk);
    frame_select_n <= 1'b1;
    mosi <= ~mosi;
    repeat (12) @(posedge clk);
  endtask
endmodule // scpd_host
`default_nettype wire

// ==== sim/spi_control_phase_decoder_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module spi_control_phase_decoder_test;
  logic clk, nrst;
  logic [7:0] rd_data;
  wire sclk, frame_select_n, mosi, miso, miso_oe, hdr_valid_r, access_direction_r;
  wire wr_stb_r, rd_stb_r, frame_end_r, invalid_block_r;
  wire [15:0] offset_r;
  wire [2:0] block_class_r, socket_r, fixed_len_r;
  wire [1:0] length_mode_r;
  wire [7:0] wr_data_r;
  int failures = 0, check_count = 0, wcnt = 0, fcnt = 0, rcnt = 0;
  logic [7:0] wlast;
  scpd_decoder DUT (.*);
  scpd_host u_host (.clk, .miso, .sclk, .frame_select_n, .mosi);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (wr_stb_r)
    begin
      wcnt <= wcnt + 1;
      wlast <= wr_data_r;
    end
  always @(posedge clk)
    if (frame_end_r)
      fcnt <= fcnt + 1;
  always @(posedge clk)
    if (rd_stb_r)
      rcnt <= rcnt + 1;
  task automatic frame(input logic [4:0] bs, input logic dir, input logic [1:0] lm,
                       input logic [31:0] d, input int nb, output logic [31:0] r);
    u_host.sel;
    u_host.bits({16'hb1e7, bs, dir, lm}, 24, r);
    u_host.bits(d, 8 * nb, r);
  endtask
  task automatic t_classes;
    logic [31:0] r;
    logic [2:0] ecls;
    int w0;
    for (int b = 0; b < 32; b++)
    begin
      ecls = (b == 0) ? 3'h1 : (b[1:0] == 2'h0) ? 3'h5 : {1'b0, b[1:0]} + 3'h1;
      w0 = wcnt;
      frame(b[4:0], 1'b1, 2'h1, {24'h0, ~b[4:0], 3'h5}, 1, r);
      `CHK(block_class_r, ecls)
      `CHK(socket_r, b[4:2])
      `CHK(invalid_block_r, ecls == 3'h5)
      `CHK(wcnt - w0, (ecls == 3'h5) ? 0 : 1)
      `CHK(hdr_valid_r, 1'b1)
      u_host.rel;
      `CHK(hdr_valid_r, 1'b0)
    end
    $display("test classes done");
  endtask
  task automatic t_modes;
    logic [31:0] r;
    int w0;
    int f0;
    int en[4] = '{4, 1, 2, 4};
    logic [7:0] el[4] = '{8'h3c, 8'hc3, 8'ha5, 8'h3c};
    for (int m = 0; m < 4; m++)
    begin
      w0 = wcnt;
      f0 = fcnt;
      frame(5'h0a, 1'b1, m[1:0], 32'hc3a55a3c, 4, r);
      `CHK(fixed_len_r, (m == 0) ? 3'h0 : 3'(en[m]))
      `CHK(length_mode_r, m[1:0])
      `CHK(offset_r, 16'hb1e7)
      `CHK(wcnt - w0, en[m])
      `CHK(wlast, el[m])
      u_host.rel;
      `CHK(fcnt - f0, (m == 0) ? 1 : 2)
    end
    $display("test modes done");
  endtask
  task automatic t_read;
    logic [31:0] r;
    int r0;
    r0 = rcnt;
    frame(5'h0b, 1'b0, 2'h0, 32'h0, 2, r);
    `CHK(access_direction_r, 1'b0)
    `CHK(miso_oe, 1'b1)
    `CHK(r[15:0], 16'hc4c4)
    `CHK(rcnt - r0, 3)
    u_host.rel;
    `CHK(miso_oe, 1'b0)
    r0 = rcnt;
    frame(5'h08, 1'b0, 2'h0, 32'h0, 2, r);
    `CHK(r[15:0], 16'h0000)
    `CHK(rcnt - r0, 0)
    u_host.rel;
    $display("test read done");
  endtask
  task automatic t_cut;
    logic [31:0] r;
    int f0;
    f0 = fcnt;
    u_host.sel;
    u_host.bits(32'h0000b1e7, 12, r);
    u_host.rel;
    `CHK(hdr_valid_r, 1'b0)
    `CHK(block_class_r, 3'h0)
    `CHK(fcnt - f0, 1)
    $display("test cut done");
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b0;
    rd_data = 8'hc4;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_classes;
    t_cut;
    t_modes;
    t_read;
    close_out;
  end
endmodule // spi_control_phase_decoder_test
`default_nettype wire
